// ---- core/gstc_pkg.sv ----
// ----------------------------------------------------------------------
// gated sixteen-bit timer/counter shared definitions
// ----------------------------------------------------------------------
package gstc_pkg;

  // register byte offsets, one aligned word each
  localparam logic [4:0] OFS_COUNT_LO = 5'h00; // count_low_byte
  localparam logic [4:0] OFS_COUNT_HI = 5'h04; // count_high_byte
  localparam logic [4:0] OFS_CTRL     = 5'h08; // timer_control_reg
  localparam logic [4:0] OFS_GATE     = 5'h0c; // gate_control_reg
  localparam logic [4:0] OFS_STATUS   = 5'h10; // live block state

  // timer_control_reg field positions
  localparam int CTRL_RUN   = 0; // run_bit
  localparam int CTRL_CS_LO = 1; // clock_select_field, two bits
  localparam int CTRL_ASYNC = 3; // 1: external edges not aligned
  localparam int CTRL_PS_LO = 4; // prescale exponent, two bits

  // gate_control_reg field positions
  localparam int GATE_EN = 0; // gate_enable_bit

  // status register field positions
  localparam int ST_ARMED = 0; // falling edge seen, rise may count
  localparam int ST_GATE  = 1; // synchronised gate level
  localparam int ST_EXT   = 2; // synchronised external clock level
  localparam int ST_RUN   = 3; // counter currently enabled

  // clock_select_field encodings
  localparam logic [1:0] CS_INSTR = 2'h0; // system clock / 4
  localparam logic [1:0] CS_FOSC  = 2'h1; // system clock
  localparam logic [1:0] CS_EXT   = 2'h2; // external_clock_pin
  localparam logic [1:0] CS_LFOSC = 2'h3; // low_freq_internal_osc

  // instruction cycle is four system clocks
  localparam logic [1:0] PHASE_LAST = 2'h3;

  // reset values
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [1:0]  CS_RST    = 2'h0;
  localparam logic [1:0]  PS_RST    = 2'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // widest prescale count (ratio up to eight)
  localparam int PRE_W = 3;

  // all state of the block
  typedef struct packed {
    logic [15:0]      count;    // running count
    logic [PRE_W-1:0] pre;      // prescaler count
    logic [1:0]       phase;    // instruction cycle phase
    logic             run;      // run_bit
    logic [1:0]       cs;       // clock_select_field
    logic             ext_async;// external edge alignment off
    logic [1:0]       ps;       // prescale exponent
    logic             gate_en;  // gate_enable_bit
    logic             ext_s1;   // external pin sync stage one
    logic             ext_s2;   // external pin sync stage two
    logic             ext_prev; // previous synced external level
    logic             gate_s1;  // gate pin sync stage one
    logic             gate_s2;  // gate pin sync stage two
    logic             lf_s1;    // slow oscillator sync stage one
    logic             lf_s2;    // slow oscillator sync stage two
    logic             lf_prev;  // previous synced slow level
    logic             armed;    // falling edge registered
    logic             pend;     // aligned external edge waiting
    logic             ack;      // bus answer cycle
    logic [31:0]      rdata;    // read data
  } gstc_state_t;

endpackage

// ---- core/gstc_top.sv ----
// The placing of the registers and register access over Avalon-MM were decided locally.
`timescale 1ns/100ps
// Contract
// - 16-bit counter, byte writes replace count
// - internal source advances once per instruction
// - external source counts each rising edge
// - run and gate-enable decide counting
// - two-bit select picks one of four
// - system clock source gives four counts
// - internal source divided by prescaler setting
// - external mode counts pin rising edges
// - external edges aligned or taken directly
// - falling edge needed before first rise
module gstc_top #(
  parameter int PRE_BITS = gstc_pkg::PRE_W // prescaler width
)(
  input  wire logic        CLK,             // 20 MHz system clock
  input  wire logic        RESET,           // synchronous, high
  input  wire logic        CE,              // clock enable
  input  wire logic [4:0]  AVS_ADDRESS,     // byte address
  input  wire logic        AVS_READ,        // read request
  input  wire logic        AVS_WRITE,       // write request
  input  wire logic [3:0]  AVS_BYTEENABLE,  // byte lanes
  input  wire logic [31:0] AVS_WRITEDATA,   // write data
  output logic      [31:0] AVS_READDATA,    // read data
  output logic             AVS_WAITREQUEST, // stall
  input  wire logic        EXT_CLOCK_PIN,   // external_clock_pin
  input  wire logic        GATE_INPUT_PIN,  // gate_input_pin
  input  wire logic        LF_OSC_IN,       // low_freq_internal_osc
  output logic      [15:0] COUNT            // running count
);

  // ----------------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------------
  localparam gstc_pkg::gstc_state_t RST_STATE = '{
    count:     gstc_pkg::COUNT_RST,
    cs:        gstc_pkg::CS_RST,
    ps:        gstc_pkg::PS_RST,
    rdata:     gstc_pkg::RDATA_RST,
    default:   '0
  };

  gstc_pkg::gstc_state_t q;        // registered state
  gstc_pkg::gstc_state_t d;        // next state
  logic                  req;      // any bus request
  logic                  wr_ack;   // write takes effect now
  logic                  wr_lo;    // low byte write
  logic                  wr_hi;    // high byte write
  logic                  wr_cnt;   // either count byte written
  logic                  count_en; // counting permitted
  logic                  ext_rise; // synced external rising edge
  logic                  ext_fall; // synced external falling edge
  logic                  lf_rise;  // synced slow oscillator edge
  logic                  last_ph;  // final phase of instruction
  logic                  src_tick; // selected source event
  logic                  pre_tick; // prescaler carry, counter steps
  logic [PRE_BITS-1:0]   pre_mask; // prescaler compare mask

  // mask of the low prescaler bits for a given exponent
  function automatic logic [PRE_BITS-1:0] pre_mask_f(
    input logic [1:0] ps
  );
    logic [PRE_BITS-1:0] m;
    m = '0;
    for (int i = 0; i < PRE_BITS; i++)
    begin
      m[i] = (i < int'(ps));
    end
    return m;
  endfunction

  // address compare for a register word
  function automatic logic hit_f(
    input logic [4:0] addr,
    input logic [4:0] ofs
  );
    return addr == ofs;
  endfunction

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    d = q;
    // bus handshake: one wait cycle, then answer
    req    = AVS_READ | AVS_WRITE;
    wr_ack = AVS_WRITE & q.ack & AVS_BYTEENABLE[0];
    wr_lo  = wr_ack & hit_f(AVS_ADDRESS, gstc_pkg::OFS_COUNT_LO);
    wr_hi  = wr_ack & hit_f(AVS_ADDRESS, gstc_pkg::OFS_COUNT_HI);
    wr_cnt = wr_lo | wr_hi;

    // gate level may come from an async source upstream
    count_en = q.run & (~q.gate_en | q.gate_s2);

    // two-stage synchronisers, then edge history
    d.ext_s1   = EXT_CLOCK_PIN;
    d.ext_s2   = q.ext_s1;
    d.ext_prev = q.ext_s2;
    d.gate_s1  = GATE_INPUT_PIN;
    d.gate_s2  = q.gate_s1;
    d.lf_s1    = LF_OSC_IN;
    d.lf_s2    = q.lf_s1;
    d.lf_prev  = q.lf_s2;
    ext_rise   = q.ext_s2 & ~q.ext_prev;
    ext_fall   = ~q.ext_s2 & q.ext_prev;
    lf_rise    = q.lf_s2 & ~q.lf_prev;

    // instruction cycle phase runs free
    d.phase = 2'(q.phase + 2'h1);
    last_ph = (q.phase == gstc_pkg::PHASE_LAST);

    // source select
    unique case (q.cs)
      gstc_pkg::CS_INSTR:
        src_tick = last_ph;
      gstc_pkg::CS_FOSC:
        src_tick = 1'b1;
      gstc_pkg::CS_EXT:
        // direct edge, or edge held to instruction boundary
        src_tick = q.ext_async ? (ext_rise & q.armed)
                               : (q.pend & last_ph);
      gstc_pkg::CS_LFOSC:
        src_tick = lf_rise;
    endcase

    // arming: a fall must precede the first counted rise
    if (!count_en || wr_cnt)
    begin
      d.armed = 1'b0;
      d.pend  = 1'b0;
    end
    else
    begin
      // fall arms, armed rise is queued in aligned mode
      if (ext_fall)
      begin
        d.armed = 1'b1;
      end
      d.pend = (q.pend & ~last_ph)
             | (ext_rise & q.armed & ~q.ext_async
                & (q.cs == gstc_pkg::CS_EXT));
    end

    // prescaler divides the selected source
    pre_mask = pre_mask_f(q.ps);
    pre_tick = count_en & src_tick
             & ((q.pre & pre_mask) == pre_mask);
    if (count_en && src_tick)
    begin
      d.pre = PRE_BITS'(q.pre + 1'b1);
    end
    if (pre_tick)
    begin
      d.count = 16'(q.count + 16'h0001);
    end

    // software byte writes win over a same-cycle step
    if (wr_cnt)
    begin
      d.pre = '0;
    end
    if (wr_lo)
    begin
      d.count[7:0] = AVS_WRITEDATA[7:0];
    end
    if (wr_hi)
    begin
      d.count[15:8] = AVS_WRITEDATA[7:0];
    end

    // control registers
    if (wr_ack && hit_f(AVS_ADDRESS, gstc_pkg::OFS_CTRL))
    begin
      d.run       = AVS_WRITEDATA[gstc_pkg::CTRL_RUN];
      d.cs        = AVS_WRITEDATA[gstc_pkg::CTRL_CS_LO +: 2];
      d.ext_async = AVS_WRITEDATA[gstc_pkg::CTRL_ASYNC];
      d.ps        = AVS_WRITEDATA[gstc_pkg::CTRL_PS_LO +: 2];
    end
    if (wr_ack && hit_f(AVS_ADDRESS, gstc_pkg::OFS_GATE))
    begin
      d.gate_en = AVS_WRITEDATA[gstc_pkg::GATE_EN];
    end

    // read data captured in the wait cycle
    d.ack = req & ~q.ack;
    if (req && !q.ack)
    begin
      d.rdata = '0;                                // unmapped reads 0
      if (hit_f(AVS_ADDRESS, gstc_pkg::OFS_COUNT_LO))
      begin
        d.rdata[7:0] = q.count[7:0];
      end
      else if (hit_f(AVS_ADDRESS, gstc_pkg::OFS_COUNT_HI))
      begin
        d.rdata[7:0] = q.count[15:8];
      end
      else if (hit_f(AVS_ADDRESS, gstc_pkg::OFS_CTRL))
      begin
        d.rdata[gstc_pkg::CTRL_RUN]        = q.run;
        d.rdata[gstc_pkg::CTRL_CS_LO +: 2] = q.cs;
        d.rdata[gstc_pkg::CTRL_ASYNC]      = q.ext_async;
        d.rdata[gstc_pkg::CTRL_PS_LO +: 2] = q.ps;
      end
      else if (hit_f(AVS_ADDRESS, gstc_pkg::OFS_GATE))
      begin
        d.rdata[gstc_pkg::GATE_EN] = q.gate_en;
      end
      else if (hit_f(AVS_ADDRESS, gstc_pkg::OFS_STATUS))
      begin
        d.rdata[gstc_pkg::ST_ARMED] = q.armed;
        d.rdata[gstc_pkg::ST_GATE]  = q.gate_s2;
        d.rdata[gstc_pkg::ST_EXT]   = q.ext_s2;
        d.rdata[gstc_pkg::ST_RUN]   = count_en;
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  // reset wins, clock enable low freezes everything
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      q <= RST_STATE;
    end
    else if (CE)
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // clock enable low keeps the stall, so a frozen write is not lost
  assign AVS_WAITREQUEST = req & ~(q.ack & CE); // answer on second edge
  assign AVS_READDATA    = q.rdata;
  assign COUNT           = q.count;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  // low byte write lands on the next edge
  lo_write_a: assert property (
    CE && wr_lo |=> q.count[7:0] == $past(AVS_WRITEDATA[7:0]))
    else $error("low byte write not applied");

  // instruction source: one step on the last phase of each instruction
  instr_step_a: assert property (
    CE && q.cs == gstc_pkg::CS_INSTR && count_en && q.ps == 2'h0
    && !wr_cnt && last_ph |=> q.count == 16'($past(q.count) + 16'h0001))
    else $error("instruction tick did not step count");

  // stopped counter never moves on its own
  run_off_a: assert property (
    !q.run && !wr_cnt |=> $stable(q.count))
    else $error("count moved while stopped");

  // gate closed holds the count
  gate_hold_a: assert property (
    q.run && q.gate_en && !q.gate_s2 && !wr_cnt |=> $stable(q.count))
    else $error("count moved with gate closed");

  // system clock source steps every clock, four per instruction
  fosc_rate_a: assert property (
    (CE && q.cs == gstc_pkg::CS_FOSC && count_en && q.ps == 2'h0
    && !wr_cnt) [*4] |=> q.count == 16'($past(q.count, 4) + 16'h0004))
    else $error("system clock rate wrong");

  // count write clears the prescaler
  pre_clear_a: assert property (
    CE && wr_cnt |=> q.pre == '0)
    else $error("prescaler not cleared by write");

  // disable or write drops the arming
  arm_clear_a: assert property (
    CE && (wr_cnt || !count_en) |=> !q.armed && !q.pend)
    else $error("arming survived disable or write");

  // unarmed external mode never counts
  ext_unarmed_a: assert property (
    q.cs == gstc_pkg::CS_EXT && !q.armed && !q.pend && !wr_cnt
    |=> $stable(q.count))
    else $error("external count without falling edge");

  // direct mode counts an armed rise on the next edge
  async_edge_a: assert property (
    CE && q.cs == gstc_pkg::CS_EXT && q.ext_async && count_en
    && q.armed && ext_rise && q.ps == 2'h0 && !wr_cnt
    |=> q.count == 16'($past(q.count) + 16'h0001))
    else $error("armed external rise not counted");

  // aligned mode waits for the instruction boundary
  sync_align_a: assert property (
    CE && q.cs == gstc_pkg::CS_EXT && !q.ext_async && !last_ph
    && !wr_cnt |=> $stable(q.count))
    else $error("aligned count off instruction boundary");

  // second sync stage copies the first
  sync_chain_a: assert property (
    CE |=> q.ext_s2 == $past(q.ext_s1))
    else $error("external synchroniser broken");

endmodule

// ---- dv/gstc_ext_src.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// external clock source on the pin
// ----------------------------------------------------------------------
module gstc_ext_src #(
  parameter int HALF = 4 // cycles high, then cycles low
)(
  input  wire logic clk,  // system clock
  input  wire logic fire, // request one pulse
  output logic      pin,  // external clock level
  output logic      busy  // pulse in progress
);
  int cnt; // cycles into the pulse

  initial
  begin
    pin  = 1'b0;
    busy = 1'b0;
    cnt  = 0;
  end

  // one rise then one fall; idles low between pulses
  always @(posedge clk)
  begin
    if (fire && !busy)
    begin
      busy <= 1'b1;
      cnt  <= 0;
      pin  <= 1'b1;
    end
    else if (busy)
    begin
      cnt <= cnt + 1;
      if (cnt == HALF - 1)
        pin <= 1'b0;
      if (cnt == 2 * HALF - 1)
        busy <= 1'b0;
    end
  end
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic        CLK, RESET, CE, AVS_READ, AVS_WRITE;
  logic [4:0]  AVS_ADDRESS;
  logic [3:0]  AVS_BYTEENABLE;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA;
  logic        AVS_WAITREQUEST, EXT_CLOCK_PIN, GATE_INPUT_PIN;
  logic        LF_OSC_IN;
  logic [15:0] COUNT;
  logic        fire, busy; // pulse request to the source
  logic [3:0]  lf_cnt;     // slow oscillator divider
  logic [31:0] q;          // last read data
  int          fails, comparisons;

  gstc_top i_gstc_top (.CLK(CLK), .RESET(RESET), .CE(CE),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .EXT_CLOCK_PIN(EXT_CLOCK_PIN),
    .GATE_INPUT_PIN(GATE_INPUT_PIN), .LF_OSC_IN(LF_OSC_IN),
    .COUNT(COUNT));

  gstc_ext_src i_gstc_ext_src (.clk(CLK), .fire(fire),
    .pin(EXT_CLOCK_PIN), .busy(busy));

  // 20 MHz clock and a 16-cycle slow oscillator
  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  initial lf_cnt = 4'h0;
  always @(posedge CLK) lf_cnt <= lf_cnt + 4'h1;
  assign LF_OSC_IN = lf_cnt[3];

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic finish_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one bus access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    AVS_ADDRESS   <= a;
    AVS_WRITEDATA <= {24'h00_0000, d};
    AVS_WRITE     <= wr;
    AVS_READ      <= !wr;
    do
    begin
      @(posedge CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      fails++;
      finish_test;
    end
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ  <= 1'b0;
  endtask

  // count gained over k cycles
  task automatic measure(input int k, output logic [15:0] d);
    logic [15:0] c0;
    @(posedge CLK);
    c0 = COUNT;
    repeat (k) @(posedge CLK);
    d = COUNT - c0;
  endtask

  // cycles per count step for a source and prescale
  function automatic int period(input logic [1:0] cs,
                                input logic [1:0] ps);
    case (cs)
      2'h0:    return 4 << ps;
      2'h1:    return 1 << ps;
      default: return 16 << ps;
    endcase
  endfunction

  // one pin pulse, then compare the count
  task automatic pulse_chk(input logic [15:0] exp);
    int n;
    n = 0;
    @(posedge CLK);
    fire <= 1'b1;
    @(posedge CLK);
    fire <= 1'b0;
    do
    begin
      @(posedge CLK);
      n++;
    end while (busy !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      fails++;
      finish_test;
    end
    repeat (8) @(posedge CLK);
    check("ext count", {16'h0000, COUNT}, {16'h0000, exp});
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    int i, m;
    logic [1:0]  cs, ps;
    logic [7:0]  lo, hi, c;
    logic [15:0] d;
    logic [4:0]  ofs[6];
    ofs = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14};
    void'($urandom(75));
    RESET = 1'b1;
    CE = 1'b1;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_ADDRESS = 5'h00;
    AVS_BYTEENABLE = 4'hf;
    AVS_WRITEDATA = 32'h0000_0000;
    GATE_INPUT_PIN = 1'b0;
    fire = 1'b0;
    fails = 0;
    comparisons = 0;
    repeat (20) @(posedge CLK);
    RESET <= 1'b0;
    // reset values, unmapped place ignores writes
    bus(1'b1, 5'h14, 8'hff);
    foreach (ofs[j])
    begin
      bus(1'b0, ofs[j], 8'h00);
      check("reset read", q, 32'h0000_0000);
    end
    // byte writes replace the count
    lo = 8'($urandom);
    hi = 8'($urandom);
    bus(1'b1, 5'h00, lo);
    bus(1'b1, 5'h04, hi);
    bus(1'b0, 5'h00, 8'h00);
    check("low byte", q, {24'h00_0000, lo});
    bus(1'b0, 5'h04, 8'h00);
    check("high byte", q, {24'h00_0000, hi});
    check("count", {16'h0000, COUNT}, {16'h0000, hi, lo});
    // internal sources and every prescale
    for (i = 0; i < 12; i++)
    begin
      cs = (i % 3 == 2) ? 2'h3 : 2'(i % 3);
      ps = 2'(i / 3);
      c = {2'h0, ps, 1'b0, cs, 1'b1};
      bus(1'b1, 5'h08, c);
      bus(1'b0, 5'h08, 8'h00);
      check("control", q, {24'h00_0000, c});
      m = $urandom_range(1, 8);
      measure(m * period(cs, ps), d);
      check("rate", {16'h0000, d}, m);
    end
    // run and gate enable table
    for (i = 0; i < 8; i++)
    begin
      GATE_INPUT_PIN <= i[2];
      bus(1'b1, 5'h0c, {7'h00, i[1]});
      bus(1'b1, 5'h08, {7'h01, i[0]});
      repeat (6) @(posedge CLK);
      measure(16, d);
      check("gated", {16'h0000, d},
            (i[0] && (!i[1] || i[2])) ? 16 : 0);
    end
    bus(1'b1, 5'h0c, 8'h00);
    // clock enable low freezes a running count
    CE <= 1'b0;
    measure(16, d);
    check("frozen", {16'h0000, d}, 32'h0000_0000);
    CE <= 1'b1;
    // external pin, aligned and direct
    for (i = 0; i < 2; i++)
    begin
      bus(1'b1, 5'h08, 8'h00);
      bus(1'b1, 5'h00, 8'h00);
      bus(1'b1, 5'h04, 8'h00);
      bus(1'b1, 5'h08, {4'h0, i[0], 3'h5});
      pulse_chk(16'h0000);
      bus(1'b0, 5'h10, 8'h00);
      check("status", q, 32'h0000_000b);
      pulse_chk(16'h0001);
      pulse_chk(16'h0002);
      bus(1'b1, 5'h08, {4'h0, i[0], 3'h4});
      pulse_chk(16'h0002);
      bus(1'b1, 5'h08, {4'h0, i[0], 3'h5});
      pulse_chk(16'h0002);
      pulse_chk(16'h0003);
      bus(1'b1, 5'h00, 8'h10);
      pulse_chk(16'h0010);
      pulse_chk(16'h0011);
    end
    finish_test;
  end
endmodule
